// file: pkhc_pkg.sv
`default_nettype none
// shared constants and types for the peak and hold predriver control
package pkhc_pkg;
    // serial frame layout: write flag, 7-bit address, 8-bit data
    localparam int          FRAME_BITS      = 16;
    localparam logic [3:0]  LAST_BIT_CNT    = 4'hF;
    localparam logic [3:0]  BIT_CNT_RESET   = 4'h0;
    localparam logic [3:0]  BIT_CNT_STEP    = 4'h1;

    // register addresses carried in the frame
    localparam logic [6:0]  ADDR_PEAK       = 7'h00;
    localparam logic [6:0]  ADDR_AUX        = 7'h01;
    localparam logic [6:0]  ADDR_HOLD       = 7'h02;
    localparam logic [6:0]  ADDR_DWELL      = 7'h03;
    localparam logic [6:0]  ADDR_FAULT      = 7'h04;

    // field positions in the auxiliary configuration register
    localparam int          AUX_PCLK_LEVEL  = 3;
    localparam int          AUX_OV_LOCK     = 6;

    // values after reset, plus the dwell count step and the unmapped readback
    localparam logic [7:0]  PEAK_RESET      = 8'h00;
    localparam logic [7:0]  AUX_RESET       = 8'h00;
    localparam logic [7:0]  HOLD_RESET      = 8'h00;
    localparam logic [7:0]  DWELL_RESET     = 8'h00;
    localparam logic [7:0]  DWELL_STEP      = 8'h01;
    localparam logic [15:0] TX_RESET        = 16'h0000;
    localparam logic [7:0]  UNMAPPED_DATA   = 8'h00;

    // fault flag positions
    localparam int          FLT_OVERVOLT    = 0;
    localparam int          FLT_OVERCUR     = 1;
    localparam int          FLT_DESAT_GATE  = 2;
    localparam int          FLT_DESAT_CLAMP = 3;
    localparam int          FLT_W           = 4;

    // serial clock ceiling against the system clock
    localparam int          SYS_CLK_KHZ     = 40000;
    localparam int          SCLK_MAX_KHZ    = 4000;
    localparam int          SCLK_MIN_CYC    = SYS_CLK_KHZ / SCLK_MAX_KHZ;
    // system cycles from frame end until the word takes effect
    localparam int          FRAME_LAT_CYC   = 4;

    // one received serial frame
    typedef struct packed {
        logic       wr;
        logic [6:0] addr;
        logic [7:0] data;
    } pkhc_frame_type;

    // dwell phase of the current drive command
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_PEAK = 2'b01,
        PH_HOLD = 2'b10
    } pkhc_phase_type;
endpackage
`default_nettype wire

// file: pkhc_ctl.sv
// Contract
// - drive allowed only while enable and cycle control are both high
// - compare sampled current with 7-bit threshold, gate on below it
// - host sets peak, hold and dwell time through the serial port
// - dwell-select input picks peak or hold threshold for comparison
// - aux bit 3: 0 dwell input is a clock, 1 a level
// - serial frames are 16 bits, serial clock up to 4 MHz
// - data moves only while chip select is held low
// - serial input bits shift into the shift register
// - serial output shifts out data, high impedance while deselected
// - loop output low while current below selected threshold, else high
// - fault pulls open-drain fault line low at once
// - fault details are recorded and readable over the serial port
// - fault removes gate drive to protect the external switches; overvoltage does so only with aux bit 6 set
// - aux bit 6 with overvoltage disables gate, clamp stays active
`timescale 1ns/1ps
`default_nettype none
module pkhc_ctl
    import pkhc_pkg::*;
#(
    parameter int THR_W = 7
) (
    // system clock, reset and freeze
    input  wire logic             SYS_CLK_IN,
    input  wire logic             RST_IN,
    input  wire logic             CLK_EN_IN,
    // serial port
    input  wire logic             SCLK_IN,
    input  wire logic             CHIP_SELECT_N_IN,
    input  wire logic             SI_IN,
    output var  logic             SO_OUT,
    output var  logic             SO_OE_OUT,
    // command and dwell pins
    input  wire logic             DRIVE_ENABLE_IN,
    input  wire logic             CYCLE_CONTROL_IN,
    input  wire logic             DWELL_SELECT_IN,
    // sampled current and fault detectors
    input  wire logic [THR_W-1:0] SENSE_CODE_IN,
    input  wire logic             OVERVOLT_IN,
    input  wire logic             OVERCUR_IN,
    input  wire logic             DESAT_GATE_IN,
    input  wire logic             DESAT_CLAMP_IN,
    // predriver and status outputs
    output var  logic             GATE_DRIVE_OUT,
    output var  logic             CLAMP_DRIVE_OUT,
    output var  logic             LOOP_STATE_OUT,
    output var  logic             FAULT_N_OUT,
    output var  logic             FAULT_OE_OUT
);
    localparam int PIN_W = THR_W + 7;

    // thresholds live in 8-bit registers, so wider codes cannot be served
    generate
        if (THR_W < 1 || THR_W > 8) begin : g_bad_width
            $error("THR_W must lie between 1 and 8");
        end
    endgenerate
    // serial clock domain
    logic [3:0]     bit_cnt_r;
    logic [15:0]    rx_sh_r;
    logic [15:0]    rx_hold_r;
    logic           rx_tgl_r;
    logic           so_r;
    logic           so_oe_r;
    logic [15:0]    tx_word_r;
    wire            cs_idle;
    wire [15:0]     rx_word;
    // frame logic is cleared by the deselect itself, so no sclk edge
    // is needed after the last bit of a frame
    assign cs_idle = CHIP_SELECT_N_IN | RST_IN;
    assign rx_word = {rx_sh_r[14:0], SI_IN};
    // sample input on falling edge, count bits of the frame
    always_ff @(negedge SCLK_IN or posedge cs_idle) begin
        if (cs_idle) begin
            bit_cnt_r <= BIT_CNT_RESET;
            rx_sh_r   <= TX_RESET;
        end else begin
            rx_sh_r   <= rx_word;
            bit_cnt_r <= bit_cnt_r + BIT_CNT_STEP;
        end
    end
    // hold the completed word and announce it by a toggle
    always_ff @(negedge SCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            rx_hold_r <= TX_RESET;
            rx_tgl_r  <= 1'b0;
        end else if (!CHIP_SELECT_N_IN && bit_cnt_r == LAST_BIT_CNT) begin
            rx_hold_r <= rx_word;
            rx_tgl_r  <= ~rx_tgl_r;
        end
    end
    // drive output on rising edge; tx_word_r is quiet during a frame
    // as long as the host keeps the gap between frames
    always_ff @(posedge SCLK_IN or posedge cs_idle) begin
        if (cs_idle) begin
            so_r    <= 1'b0;
            so_oe_r <= 1'b0;
        end else begin
            so_r    <= tx_word_r[~bit_cnt_r];
            so_oe_r <= 1'b1;
        end
    end
    assign SO_OUT    = so_r;
    assign SO_OE_OUT = so_oe_r;
    // system clock domain
    logic [2:0]         tgl_sync_r;
    logic [PIN_W-1:0]   pin_s1_r;
    logic [PIN_W-1:0]   pin_s2_r;
    logic               pclk_d_r;
    logic [7:0]         peak_r;
    logic [7:0]         aux_r;
    logic [7:0]         hold_r;
    logic [7:0]         dwell_r;
    logic [7:0]         dwell_cnt_r;
    logic [FLT_W-1:0]   fault_r;
    logic               configured_r;
    pkhc_phase_type     phase_r;
    pkhc_phase_type     phase_nxt;
    logic               gate_r;
    logic               clamp_r;
    logic               loop_r;
    logic               fault_oe_r;
    logic               fault_n_r;
    // received frame announcement and its decode
    wire                frame_stb;
    pkhc_frame_type     frm;
    wire                wr_peak;
    wire                wr_aux;
    wire                wr_hold;
    wire                wr_dwell;
    wire                rd_fault;
    wire [7:0]          rd_data;
    wire [7:0]          status_byte;
    assign frame_stb = tgl_sync_r[1] ^ tgl_sync_r[2];
    assign frm       = pkhc_frame_type'(rx_hold_r);
    assign wr_peak   = frame_stb && frm.wr && frm.addr == ADDR_PEAK;
    assign wr_aux    = frame_stb && frm.wr && frm.addr == ADDR_AUX;
    assign wr_hold   = frame_stb && frm.wr && frm.addr == ADDR_HOLD;
    assign wr_dwell  = frame_stb && frm.wr && frm.addr == ADDR_DWELL;
    assign rd_fault  = frame_stb && !frm.wr && frm.addr == ADDR_FAULT;
    // readback selection, unmapped addresses answer zero
    assign rd_data = (frm.addr == ADDR_PEAK)  ? peak_r  :
                     (frm.addr == ADDR_AUX)   ? aux_r   :
                     (frm.addr == ADDR_HOLD)  ? hold_r  :
                     (frm.addr == ADDR_DWELL) ? dwell_r :
                     (frm.addr == ADDR_FAULT) ?
                         {{(8-FLT_W){1'b0}}, fault_r} : UNMAPPED_DATA;
    assign status_byte = {loop_r, gate_r, clamp_r, configured_r, fault_r};
    // synchronised pins
    wire                cmd;
    wire                pclk_s;
    wire [FLT_W-1:0]    fault_in;
    wire [THR_W-1:0]    sense;
    assign cmd      = pin_s2_r[PIN_W-1] & pin_s2_r[PIN_W-2];
    assign pclk_s   = pin_s2_r[PIN_W-3];
    assign fault_in = pin_s2_r[THR_W+3:THR_W];
    assign sense    = pin_s2_r[THR_W-1:0];
    // dwell and threshold selection
    wire                level_mode;
    wire                pclk_rise;
    wire                sel_peak;
    wire [THR_W-1:0]    thr;
    wire                below;
    assign level_mode = aux_r[AUX_PCLK_LEVEL];
    assign pclk_rise  = pclk_s & ~pclk_d_r;
    assign sel_peak   = level_mode ? pclk_s : (phase_r == PH_PEAK);
    assign thr        = sel_peak ? peak_r[THR_W-1:0] : hold_r[THR_W-1:0];
    assign below      = sense < thr;
    // protection terms act on the live detector too, not a cycle late
    wire                any_fault;
    wire                hard_trip;
    wire                ov_lock;
    wire                want_gate;
    wire                want_clamp;
    wire                gate_nxt;
    wire                clamp_nxt;
    assign any_fault  = |(fault_r | fault_in);
    assign hard_trip  = fault_r[FLT_OVERCUR] | fault_in[FLT_OVERCUR] |
                        fault_r[FLT_DESAT_GATE] | fault_in[FLT_DESAT_GATE] |
                        fault_r[FLT_DESAT_CLAMP] |
                        fault_in[FLT_DESAT_CLAMP];
    assign ov_lock    = aux_r[AUX_OV_LOCK] &
                        (fault_r[FLT_OVERVOLT] | fault_in[FLT_OVERVOLT]);
    assign want_gate  = cmd & configured_r & below & ~hard_trip &
                        ~ov_lock;
    assign want_clamp = cmd & configured_r & ~below & ~hard_trip;
    // each drive waits for the other to be off: one cycle of dead time
    assign gate_nxt   = want_gate & ~clamp_r;
    assign clamp_nxt  = want_clamp & ~want_gate & ~gate_r;
    // dwell phase: clock mode counts dwell-input edges in peak
    always_comb begin
        phase_nxt = phase_r;
        case (phase_r)
            PH_IDLE: begin
                if (cmd) begin
                    phase_nxt = PH_PEAK;
                end
            end
            PH_PEAK: begin
                if (!cmd) begin
                    phase_nxt = PH_IDLE;
                end else if (dwell_cnt_r >= dwell_r) begin
                    phase_nxt = PH_HOLD;
                end
            end
            PH_HOLD: begin
                if (!cmd) begin
                    phase_nxt = PH_IDLE;
                end
            end
            default: begin
                phase_nxt = PH_IDLE;
            end
        endcase
    end
    // crossing of frame toggle and pins, two stages before use
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            tgl_sync_r <= 3'h0;
            pin_s1_r   <= '0;
            pin_s2_r   <= '0;
            pclk_d_r   <= 1'b0;
        end else if (CLK_EN_IN) begin
            tgl_sync_r <= {tgl_sync_r[1:0], rx_tgl_r};
            pin_s1_r   <= {DRIVE_ENABLE_IN, CYCLE_CONTROL_IN,
                           DWELL_SELECT_IN, DESAT_CLAMP_IN, DESAT_GATE_IN,
                           OVERCUR_IN, OVERVOLT_IN, SENSE_CODE_IN};
            pin_s2_r   <= pin_s1_r;
            pclk_d_r   <= pclk_s;
        end
    end
    // configuration registers written from frames
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            peak_r       <= PEAK_RESET;
            aux_r        <= AUX_RESET;
            hold_r       <= HOLD_RESET;
            dwell_r      <= DWELL_RESET;
            configured_r <= 1'b0;
        end else if (CLK_EN_IN) begin
            if (wr_peak) begin
                peak_r <= frm.data;
            end
            if (wr_aux) begin
                aux_r <= frm.data;
            end
            if (wr_hold) begin
                hold_r <= frm.data;
            end
            if (wr_dwell) begin
                dwell_r <= frm.data;
            end
            if (wr_peak || wr_aux || wr_hold || wr_dwell) begin
                configured_r <= 1'b1;
            end
        end
    end
    // sticky faults, cleared by reading them; a new event wins
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            fault_r   <= '0;
            tx_word_r <= TX_RESET;
        end else if (CLK_EN_IN) begin
            fault_r <= (fault_r & ~{FLT_W{rd_fault}}) | fault_in;
            if (frame_stb) begin
                tx_word_r <= {status_byte, rd_data};
            end
        end
    end
    // dwell counter and phase
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            phase_r     <= PH_IDLE;
            dwell_cnt_r <= DWELL_RESET;
        end else if (CLK_EN_IN) begin
            phase_r <= phase_nxt;
            if (phase_r != PH_PEAK) begin
                dwell_cnt_r <= DWELL_RESET;
            end else if (pclk_rise && dwell_cnt_r < dwell_r) begin
                dwell_cnt_r <= dwell_cnt_r + DWELL_STEP;
            end
        end
    end
    // output flops; fault line only ever pulls low
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            gate_r     <= 1'b0;
            clamp_r    <= 1'b0;
            loop_r     <= 1'b0;
            fault_oe_r <= 1'b0;
            fault_n_r  <= 1'b0;
        end else if (CLK_EN_IN) begin
            gate_r     <= gate_nxt;
            clamp_r    <= clamp_nxt;
            loop_r     <= ~below;
            fault_oe_r <= any_fault;
        end
    end
    assign GATE_DRIVE_OUT  = gate_r;
    assign CLAMP_DRIVE_OUT = clamp_r;
    assign LOOP_STATE_OUT  = loop_r;
    assign FAULT_N_OUT     = fault_n_r;
    assign FAULT_OE_OUT    = fault_oe_r;
    // checks; the frame one runs on the serial clock, within a frame
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (RST_IN);
    no_cross_cond_a: assert property (
        !(gate_r && clamp_r))
        else $error("gate and clamp drive on together");
    gate_needs_cmd_a: assert property (
        (CLK_EN_IN && !cmd) |=> !gate_r)
        else $error("gate drive without both command inputs");
    gate_follows_a: assert property (
        (CLK_EN_IN && cmd && configured_r && below && !hard_trip &&
         !ov_lock && !clamp_r) |=> gate_r)
        else $error("gate stayed off with current below threshold");
    loop_state_a: assert property (
        CLK_EN_IN |=> (loop_r == !$past(below)))
        else $error("loop output disagrees with comparison");
    fault_line_a: assert property (
        (CLK_EN_IN && (|fault_in)) |=> fault_oe_r)
        else $error("fault line not pulled low");
    fault_kept_a: assert property (
        (CLK_EN_IN && (|fault_in)) |=>
            ((fault_r & $past(fault_in)) == $past(fault_in)))
        else $error("fault event not recorded");
    trip_off_a: assert property (
        (CLK_EN_IN && hard_trip) |=> (!gate_r && !clamp_r))
        else $error("drive stayed on during a fault");
    ov_lock_a: assert property (
        (CLK_EN_IN && ov_lock) |=> !gate_r)
        else $error("gate drive on during overvoltage lockout");
    level_select_a: assert property (
        (level_mode && pclk_s) |-> (thr == peak_r[THR_W-1:0]))
        else $error("level mode did not select peak threshold");
    hold_select_a: assert property (
        (!level_mode && phase_r == PH_HOLD) |->
            (thr == hold_r[THR_W-1:0]))
        else $error("hold phase did not select hold threshold");
    peak_write_a: assert property (
        (CLK_EN_IN && wr_peak) |=> (peak_r == $past(frm.data)))
        else $error("peak threshold write lost");
    unconfig_off_a: assert property (
        !configured_r |-> (!gate_r && !clamp_r))
        else $error("drive on before configuration");
    so_hiz_a: assert property (
        (CHIP_SELECT_N_IN && $past(CHIP_SELECT_N_IN)) |-> !so_oe_r)
        else $error("serial output driven while deselected");
    frame_len_a: assert property (
        @(negedge SCLK_IN) disable iff (cs_idle)
        (bit_cnt_r != LAST_BIT_CNT) |=> (rx_tgl_r == $past(rx_tgl_r)))
        else $error("word captured before its 16th bit");
    peak_write_c: cover property (wr_peak);
    fault_read_c: cover property (rd_fault && (|fault_r));
    hold_phase_c: cover property (phase_r == PH_PEAK ##1 phase_r == PH_HOLD);
    ov_lock_c:    cover property (ov_lock && clamp_r);
endmodule
`default_nettype wire

// file: pkhc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the serial port: drives mode 1 frames, msb first
module pkhc_host_model #(
    parameter int HALF_NS = 128
) (
    // serial port seen from the host
    output var  logic SCLK_OUT,
    output var  logic CHIP_SELECT_N_OUT,
    output var  logic SI_OUT,
    input  wire logic SO_IN
);
    // idle: clock low and still, select high, data at pulldown level
    initial begin
        SCLK_OUT          = 1'b0;
        CHIP_SELECT_N_OUT = 1'b1;
        SI_OUT            = 1'b0;
    end

    // one frame of nbits; fewer than 16 bits makes an aborted frame
    // period kept below the 4 MHz serial clock ceiling
    task automatic xfer(input logic [15:0] tx, input int nbits,
                        output logic [15:0] rx);
        rx = 16'h0000;
        #7;
        CHIP_SELECT_N_OUT = 1'b0;
        #HALF_NS;
        for (int i = 15; i > 15 - nbits; i--) begin
            SCLK_OUT = 1'b1;
            SI_OUT   = tx[i];
            #HALF_NS;
            SCLK_OUT = 1'b0;
            rx[i]    = SO_IN;
            #HALF_NS;
        end
        CHIP_SELECT_N_OUT = 1'b1;
        SI_OUT            = 1'b0;
        // gap well above the 100 ns needed between frames
        #(2 * HALF_NS);
    endtask
endmodule
`default_nettype wire

// file: pkhc_ctl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) begin \
            err_total++; \
            $display("mismatch at %0t: got %h expected %h", \
                     $time, got, exp); \
        end \
    end
module pkhc_ctl_tb_top;
    import pkhc_pkg::*;
    logic        sys_clk, rst, sclk, cs_n, si, so, so_oe;
    logic        drv_en, cyc_ctl, dwell_sel, ov, oc, dg, dc;
    logic [6:0]  sense;
    logic        gate, clamp, loop_st, fault_n, fault_oe;
    logic        fault_line;
    logic [15:0] rx;
    int          err_total, cmp_count, cycles;
    integer      seed;

    // open-drain fault line with its pull-up
    assign fault_line = fault_oe ? fault_n : 1'b1;

    pkhc_ctl uut (
        .SYS_CLK_IN(sys_clk), .RST_IN(rst), .CLK_EN_IN(1'b1),
        .SCLK_IN(sclk), .CHIP_SELECT_N_IN(cs_n), .SI_IN(si),
        .SO_OUT(so), .SO_OE_OUT(so_oe),
        .DRIVE_ENABLE_IN(drv_en), .CYCLE_CONTROL_IN(cyc_ctl),
        .DWELL_SELECT_IN(dwell_sel), .SENSE_CODE_IN(sense),
        .OVERVOLT_IN(ov), .OVERCUR_IN(oc), .DESAT_GATE_IN(dg),
        .DESAT_CLAMP_IN(dc), .GATE_DRIVE_OUT(gate),
        .CLAMP_DRIVE_OUT(clamp), .LOOP_STATE_OUT(loop_st),
        .FAULT_N_OUT(fault_n), .FAULT_OE_OUT(fault_oe)
    );

    pkhc_host_model host (
        .SCLK_OUT(sclk), .CHIP_SELECT_N_OUT(cs_n),
        .SI_OUT(si), .SO_IN(so_oe ? so : ~so) // released line reads inverted
    );

    // 40 MHz system clock
    initial sys_clk = 1'b0;
    always #12.5 sys_clk = ~sys_clk;

    // hang guard, far above the few thousand cycles the tests need
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            $display("mismatch at %0t: run timed out", $time);
            tally_and_finish();
        end
    end

    function automatic logic exp_gate(input logic c, input logic [6:0] s,
                                      input logic [6:0] t);
        return c && (s < t);
    endfunction

    function automatic logic exp_clamp(input logic c, input logic [6:0] s,
                                       input logic [6:0] t);
        return c && !(s < t);
    endfunction

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // one full frame; output must be released once select is high
    task automatic spi(input logic wr, input logic [6:0] addr,
                       input logic [7:0] data);
        host.xfer({wr, addr, data}, FRAME_BITS, rx);
        @(negedge sys_clk);
        `CHK(so_oe, 1'b0)
    endtask

    // read answer arrives in the following frame
    task automatic rd(input logic [6:0] addr);
        spi(1'b0, addr, 8'h00);
        spi(1'b0, 7'h7F, 8'h00);
    endtask

    initial begin
        logic [7:0] v;
        logic [6:0] thr;
        logic [6:0] adr [4];
        logic       cmd;
        adr = '{ADDR_PEAK, ADDR_AUX, ADDR_HOLD, ADDR_DWELL};
        seed = 32'h69FF;
        {rst, drv_en, cyc_ctl, dwell_sel} = 4'h8;
        {ov, oc, dg, dc} = 4'h0;
        sense = 7'h7F;
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        // defaults: no drive before the host writes anything
        drv_en = 1'b1;
        cyc_ctl = 1'b1;
        settle(8);
        `CHK({gate, clamp}, 2'b00)
        `CHK(fault_line, 1'b1)
        spi(1'b0, ADDR_PEAK, 8'h00);
        spi(1'b0, ADDR_AUX, 8'h00);
        `CHK(rx[7:0], PEAK_RESET)
        `CHK(rx[12], 1'b0)
        spi(1'b0, 7'h7F, 8'h00);
        `CHK(rx[7:0], AUX_RESET)
        spi(1'b0, 7'h7F, 8'h00);
        `CHK(rx[7:0], UNMAPPED_DATA)
        `CHK(gate, 1'b0)
        $display("test reset done");
        // random write and readback, plus an aborted frame
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed)) & 8'h7F;
            spi(1'b1, adr[i], v);
            host.xfer({1'b1, adr[i], 8'hFF}, 9, rx);
            rd(adr[i]);
            `CHK(rx[7:0], v)
            `CHK(rx[12], 1'b1)
        end
        $display("test registers done");
        // level mode: random commands, currents and dwell levels
        spi(1'b1, ADDR_AUX, 8'h08);
        spi(1'b1, ADDR_PEAK, 8'h50);
        spi(1'b1, ADDR_HOLD, 8'h28);
        for (int i = 0; i < 32; i++) begin
            {drv_en, cyc_ctl, dwell_sel} = 3'($random(seed));
            thr = dwell_sel ? 7'h50 : 7'h28;
            sense = (i % 4 == 0) ? thr : 7'($random(seed));
            cmd = drv_en & cyc_ctl;
            settle(8);
            `CHK(gate, exp_gate(cmd, sense, thr))
            `CHK(clamp, exp_clamp(cmd, sense, thr))
            if (cmd)
                `CHK(loop_st, !(sense < thr))
        end
        $display("test level mode done");
        // clock mode: peak for three dwell edges, then hold
        {drv_en, cyc_ctl, dwell_sel} = 3'b000;
        spi(1'b1, ADDR_AUX, 8'h00);
        spi(1'b1, ADDR_PEAK, 8'h60);
        spi(1'b1, ADDR_DWELL, 8'h03);
        sense = 7'h40;
        settle(8);
        {drv_en, cyc_ctl} = 2'b11;
        settle(10);
        `CHK(gate, 1'b1)
        for (int p = 0; p < 3; p++) begin
            if (p == 2)
                `CHK({gate, clamp}, 2'b10)
            dwell_sel = 1'b1;
            settle(4);
            dwell_sel = 1'b0;
            settle(8);
        end
        `CHK({gate, clamp, loop_st}, 3'b011)
        drv_en = 1'b0;
        settle(8);
        `CHK({gate, clamp}, 2'b00)
        $display("test clock mode done");
        // each detector: fault line, protection, sticky readback
        spi(1'b1, ADDR_AUX, 8'h08);
        {drv_en, dwell_sel} = 2'b11;
        sense = 7'h10;
        for (int k = 0; k < FLT_W; k++) begin
            {dc, dg, oc, ov} = 4'(1 << k);
            settle(6);
            `CHK(fault_line, 1'b0)
            `CHK(gate, (k == 0))
            {dc, dg, oc, ov} = 4'h0;
            settle(4);
            `CHK(fault_line, 1'b0)
            rd(ADDR_FAULT);
            `CHK(rx[7:0], 8'(1 << k))
            settle(8);
            `CHK({fault_line, gate}, 2'b11)
        end
        // overvoltage lock: gate off, clamp still usable
        spi(1'b1, ADDR_AUX, 8'h48);
        ov = 1'b1;
        settle(8);
        `CHK(gate, 1'b0)
        sense = 7'h70;
        settle(8);
        `CHK(clamp, 1'b1)
        $display("test faults done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
